//--- iwdt_core.sv
`timescale 1ns/1ps
module iwdt_core
	import iwdt_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [7:0]  file_rd_data,
	input  wire logic [7:0]  alu_result,
	input  wire logic [1:0]  ptr_prog_mem,
	output logic [6:0]       file_addr,
	output logic             file_rd,
	output logic             file_wr,
	output logic [7:0]       file_wr_data,
	output logic             acc_wr,
	output logic [7:0]       acc_wr_data,
	output logic [7:0]       alu_operand,
	output logic             ptr_sel,
	output logic             ptr_step,
	output logic             ptr_down,
	output logic             cycle_tick,
	output logic             instr_done,
	output logic             skip_next
);

	// ============================================================
	// Reset release through two flip-flops
	logic rst_meta;
	logic rst_sync_b;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta   <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_b <= rst_meta;
		end
	end

	// ============================================================
	// State
	iwdt_state_t state;
	logic [1:0]  phase;
	logic [1:0]  cyc_idx;
	logic [1:0]  cyc_last;
	logic [13:0] word;
	logic [7:0]  operand;
	logic [7:0]  result;
	logic        skip_taken;
	logic [15:0] retired;
	logic        rd_ack;

	// Decoder outputs
	iwdt_group_t dec_grp;
	logic [6:0]  dec_file_addr;
	logic        dec_has_file;
	logic        dec_dest_file;
	logic [2:0]  dec_bit_num;
	logic        dec_bit_set;
	logic        dec_bit_clr;
	logic        dec_bit_test;
	logic        dec_skip_on_set;
	logic        dec_skip_dec;
	logic        dec_skip_inc;
	logic        dec_ptr_op;
	logic        dec_ind_file;
	logic        dec_ptr_num;
	logic [1:0]  dec_ptr_mode;
	logic        dec_two_cycle;
	logic        dec_ind_extra;
	logic [1:0]  dec_base_last;

	// ============================================================
	// Sequencing terms
	wire        exec      = state == ST_EXEC;
	wire        cyc0      = exec && cyc_idx == CYCLE_FIRST;
	wire        q_last    = phase == QUARTER_LAST;
	wire        calc_q    = cyc0 && phase == QUARTER_CALC;
	wire        start     = avs_write && avs_address == OFS_INSTR && !exec;
	wire [13:0] dec_word  = start ? avs_writedata[13:0] : word;
	wire        done      = exec && q_last && cyc_idx == cyc_last;

	iwdt_field_decode u_decode (
		.word        (dec_word),
		.ptr_prog_mem(ptr_prog_mem),
		.grp         (dec_grp),
		.file_addr   (dec_file_addr),
		.has_file    (dec_has_file),
		.dest_file   (dec_dest_file),
		.bit_num     (dec_bit_num),
		.bit_set_op  (dec_bit_set),
		.bit_clr_op  (dec_bit_clr),
		.bit_test    (dec_bit_test),
		.skip_on_set (dec_skip_on_set),
		.skip_dec    (dec_skip_dec),
		.skip_inc    (dec_skip_inc),
		.ptr_op      (dec_ptr_op),
		.ind_file    (dec_ind_file),
		.ptr_num     (dec_ptr_num),
		.ptr_mode    (dec_ptr_mode),
		.two_cycle   (dec_two_cycle),
		.ind_extra   (dec_ind_extra),
		.base_last   (dec_base_last)
	);

	// ============================================================
	// Next-state selection
	wire         next_state_exec = start || (exec && !done);
	iwdt_state_t next_state;
	assign next_state = next_state_exec ? ST_EXEC : ST_IDLE;

	// Quarter counter free-runs while busy, four clocks per cycle
	wire [1:0] next_phase   = exec ? phase + 2'h1 : QUARTER_FIRST;
	wire [1:0] next_cyc_idx = (!exec || done) ? CYCLE_FIRST :
	                          (q_last ? cyc_idx + 2'h1 : cyc_idx);

	// ============================================================
	// Modify stage: bit ops, count skips, else the outside ALU
	wire [7:0] bit_mask   = 8'h01 << dec_bit_num;
	wire [7:0] mod_value  = dec_bit_set  ? (operand | bit_mask) :
	                        dec_bit_clr  ? (operand & ~bit_mask) :
	                        dec_skip_dec ? (operand - 8'h01) :
	                        dec_skip_inc ? (operand + 8'h01) : alu_result;
	wire       bit_is_set = (operand & bit_mask) != 8'h00;
	wire       skip_now   = (dec_skip_dec || dec_skip_inc) ? (mod_value == 8'h00) :
	                        (dec_bit_test ? (bit_is_set == dec_skip_on_set) : 1'b0);

	// Taken skip stretches the count by one idle cycle
	wire [1:0] next_cyc_last = start ? dec_base_last :
	                           ((calc_q && skip_now) ? cyc_last + 2'h1 : cyc_last);
	wire       next_skip     = start ? 1'b0 : (calc_q ? skip_now : skip_taken);

	// Operand is caught at the read quarter, even for write-only ops
	wire [7:0] next_operand = (cyc0 && phase == QUARTER_READ && dec_has_file) ?
	                          file_rd_data : operand;
	wire [7:0] next_result  = calc_q ? mod_value : result;

	// ============================================================
	// Store routing: bit tests never store; byte ops follow d
	wire store_file = dec_has_file && !dec_bit_test &&
	                  (dec_grp == GRP_BIT || dec_dest_file);
	// Byte group without a file operand is clear-accumulator, which still stores to W
	wire store_acc  = dec_grp == GRP_BYTE && !dec_dest_file;

	// Strobes only in the first cycle, so extra and skipped cycles stay idle
	assign file_rd = cyc0 && phase == QUARTER_READ && dec_has_file;
	assign file_wr = cyc0 && q_last && store_file;
	assign acc_wr  = cyc0 && q_last && store_acc;

	// Pointer update at the first quarter for pre, the last for post
	wire ptr_pre = !dec_ptr_mode[1];
	assign ptr_step = cyc0 && dec_ptr_op &&
	                  (ptr_pre ? phase == QUARTER_FIRST : q_last);

	// Cycle markers
	assign cycle_tick = exec && q_last;
	assign instr_done = done;
	assign skip_next  = done && skip_taken;

	// Data outputs straight from flip-flops
	assign file_wr_data = result;
	assign acc_wr_data  = result;
	assign alu_operand  = operand;

	// ============================================================
	// Avalon slave: reads take one wait state, instruction writes stall while busy
	wire [31:0] status_word = {22'h000000, phase, skip_taken, dec_ind_extra,
	                           dec_ind_file, cyc_last, dec_grp, exec};
	wire [31:0] decode_word = {17'h00000, dec_has_file, dec_ptr_mode, dec_ptr_num,
	                           dec_bit_num, dec_dest_file, file_addr};
	wire [31:0] rd_mux = (avs_address == OFS_INSTR)   ? {18'h00000, word} :
	                     (avs_address == OFS_STATUS)  ? status_word :
	                     (avs_address == OFS_DECODE)  ? decode_word :
	                     (avs_address == OFS_RETIRED) ? {16'h0000, retired} : 32'h00000000;
	wire        rd_take = avs_read && !rd_ack;

	assign avs_waitrequest = rd_take || (avs_write && avs_address == OFS_INSTR && exec);

	// Bus registers
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rd_ack       <= 1'b0;
			avs_readdata <= RDATA_RST;
		end else begin
			rd_ack       <= rd_take;
			avs_readdata <= rd_take ? rd_mux : avs_readdata;
		end
	end

	// ============================================================
	// Sequencer registers
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state    <= ST_IDLE;
			phase    <= QUARTER_FIRST;
			cyc_idx  <= CYCLE_FIRST;
			cyc_last <= CYCLE_FIRST;
		end else begin
			state    <= next_state;
			phase    <= next_phase;
			cyc_idx  <= next_cyc_idx;
			cyc_last <= next_cyc_last;
		end
	end

	// Instruction latch and operand fields held for the whole instruction
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			word      <= WORD_RST;
			file_addr <= FILE_CLRACC;
			ptr_sel   <= 1'b0;
			ptr_down  <= 1'b0;
		end else if (start) begin
			word      <= avs_writedata[13:0];
			file_addr <= dec_file_addr;
			ptr_sel   <= dec_ptr_num;
			ptr_down  <= dec_ptr_mode[0];
		end
	end

	// Datapath registers
	always_ff @(posedge core_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			operand    <= DATA_RST;
			result     <= DATA_RST;
			skip_taken <= 1'b0;
			retired    <= RETIRED_RST;
		end else begin
			operand    <= next_operand;
			result     <= next_result;
			skip_taken <= next_skip;
			retired    <= done ? retired + 16'h0001 : retired;
		end
	end

	// ============================================================
	// Checks beside the logic
	quarter_period_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_b)
		cycle_tick && !done |=> !cycle_tick [*3] ##1 cycle_tick)
		else $error("instruction cycle is not four clocks");

	single_cycle_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_b)
		start && dec_base_last == 2'h0 && !dec_skip_dec && !dec_skip_inc && !dec_bit_test
		|-> ##4 instr_done)
		else $error("plain instruction did not finish in one cycle");

	two_cycle_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_b)
		start && dec_two_cycle && !dec_ind_extra |-> !instr_done [*8] ##1 instr_done)
		else $error("call or return did not take two cycles");

	indirect_extra_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_b)
		start && dec_ind_extra && !dec_two_cycle && !dec_skip_dec && !dec_skip_inc &&
		!dec_bit_test |-> ##8 instr_done)
		else $error("program memory indirect access missed its extra cycle");

	read_first_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_b)
		file_wr |-> $past(file_rd, 3))
		else $error("file register written without prior read");

	skip_stretch_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_b)
		calc_q && skip_now |=> cyc_last == $past(cyc_last) + 2'h1)
		else $error("taken skip did not add a cycle");

	skipped_idle_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_b)
		exec && cyc_idx != CYCLE_FIRST |-> !file_wr && !acc_wr && !file_rd && !ptr_step)
		else $error("state changed during an idle cycle");

	dest_route_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_b)
		acc_wr |-> !file_wr && !word[7] && dec_grp == GRP_BYTE)
		else $error("accumulator store with destination bit set");

	bus_stall_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_b)
		avs_write && avs_address == OFS_INSTR && exec |-> avs_waitrequest)
		else $error("instruction write accepted while busy");

endmodule : iwdt_core

//--- iwdt_pkg.sv
// ============================================================
// What this block does
// - Each instruction arrives as one 14-bit word with opcode and operands.
// - Words are sorted into byte, bit, or literal-and-control groups.
// - An instruction takes one instruction cycle unless an exception applies.
// - Direct call and call through the accumulator take two cycles.
// - Plain return, return with literal and interrupt return take two cycles.
// - Jumps, relative branches and taken skips take two cycles.
// - Indirect access through a pointer aimed at program memory adds a cycle.
// - One instruction cycle is four consecutive oscillator clocks.
// - File register operands are read, modified, then stored as directed.
// - The named register is read even when the instruction only writes it.
// - The address field selects file location 0x00 to 0x7F.
// - Destination bit clear stores to accumulator, set stores to file register.
// - Bit field selects one bit of the addressed 8-bit register.
// - Don't-care bits are ignored; zero or one gives the same result.
// - Pointer number selects one of two pointers and its indirect register.
// - Two-bit update field picks pre/post increment or decrement.
// - Count-down skip takes one cycle, or two when result is zero.
package iwdt_pkg;

	// ============================================================
	// Widths
	localparam int unsigned WORD_W = 14;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FADR_W = 7;

	// ============================================================
	// Avalon register byte offsets
	localparam logic [3:0] OFS_INSTR   = 4'h0;
	localparam logic [3:0] OFS_STATUS  = 4'h4;
	localparam logic [3:0] OFS_DECODE  = 4'h8;
	localparam logic [3:0] OFS_RETIRED = 4'hC;

	// ============================================================
	// Reset values
	localparam logic [13:0] WORD_RST    = 14'h0000;
	localparam logic [7:0]  DATA_RST    = 8'h00;
	localparam logic [15:0] RETIRED_RST = 16'h0000;
	localparam logic [31:0] RDATA_RST   = 32'h00000000;

	// ============================================================
	// Sequencing
	localparam logic [1:0] QUARTER_FIRST = 2'h0;
	localparam logic [1:0] QUARTER_READ  = 2'h0;
	localparam logic [1:0] QUARTER_CALC  = 2'h1;
	localparam logic [1:0] QUARTER_LAST  = 2'h3;
	localparam logic [1:0] CYCLE_FIRST   = 2'h0;

	// ============================================================
	// Opcode patterns
	localparam logic [1:0] TOP_BYTE    = 2'h0;
	localparam logic [1:0] TOP_BIT     = 2'h1;
	localparam logic [1:0] TOP_EXT     = 2'h3;
	localparam logic [1:0] BIT_CLR     = 2'h0;
	localparam logic [1:0] BIT_SET     = 2'h1;
	localparam logic [1:0] BIT_SKIPSET = 2'h3;
	localparam logic [3:0] NIB_NONE    = 4'h0;
	localparam logic [3:0] NIB_DECSKIP = 4'hB;
	localparam logic [3:0] NIB_INCSKIP = 4'hF;
	localparam logic [3:0] NIB_LSL     = 4'h5;
	localparam logic [3:0] NIB_LSR     = 4'h6;
	localparam logic [3:0] NIB_ASR     = 4'h7;
	localparam logic [3:0] NIB_SUBB    = 4'hB;
	localparam logic [3:0] NIB_ADDC    = 4'hD;
	localparam logic [6:0] OP_CLRACC   = 7'h02;
	localparam logic [2:0] OP_CALL     = 3'h4;
	localparam logic [2:0] OP_JUMP     = 3'h5;
	localparam logic [5:0] OP_RETLIT   = 6'h34;
	localparam logic [4:0] OP_RELBR    = 5'h19;
	localparam logic [9:0] OP_CTL      = 10'h000;
	localparam logic [9:0] OP_PTR      = 10'h001;
	localparam logic [3:0] CTL_RET     = 4'h8;
	localparam logic [3:0] CTL_RETINT  = 4'h9;
	localparam logic [3:0] CTL_CALLACC = 4'hA;
	localparam logic [3:0] CTL_BRACC   = 4'hB;
	localparam logic [5:0] IND_ADDR_HI = 6'h00;
	localparam logic [6:0] FILE_CLRACC = 7'h00;

	// ============================================================
	// Types
	typedef enum logic [1:0] {GRP_BYTE, GRP_BIT, GRP_LITCTL} iwdt_group_t;
	typedef enum logic {ST_IDLE, ST_EXEC} iwdt_state_t;

endpackage : iwdt_pkg

//--- iwdt_field_decode.sv
`timescale 1ns/1ps
module iwdt_field_decode
	import iwdt_pkg::*;
(
	input  wire logic [13:0] word,
	input  wire logic [1:0]  ptr_prog_mem,
	output iwdt_group_t      grp,
	output logic [6:0]       file_addr,
	output logic             has_file,
	output logic             dest_file,
	output logic [2:0]       bit_num,
	output logic             bit_set_op,
	output logic             bit_clr_op,
	output logic             bit_test,
	output logic             skip_on_set,
	output logic             skip_dec,
	output logic             skip_inc,
	output logic             ptr_op,
	output logic             ind_file,
	output logic             ptr_num,
	output logic [1:0]       ptr_mode,
	output logic             two_cycle,
	output logic             ind_extra,
	output logic [1:0]       base_last
);

	// ============================================================
	// Group sort on the top bits
	wire [1:0] top2     = word[13:12];
	wire [3:0] nib      = word[11:8];
	wire       is_clracc = word[13:7] == OP_CLRACC;
	wire       ext_byte = top2 == TOP_EXT && (nib == NIB_LSL || nib == NIB_LSR ||
	                      nib == NIB_ASR || nib == NIB_SUBB || nib == NIB_ADDC);
	wire       byte_grp = (top2 == TOP_BYTE && (nib != NIB_NONE || word[7])) || ext_byte;
	wire       bit_grp  = top2 == TOP_BIT;
	wire       ctl_grp  = word[13:4] == OP_CTL;
	wire [3:0] ctl_low  = word[3:0];

	assign grp = byte_grp ? GRP_BYTE : (bit_grp ? GRP_BIT : GRP_LITCTL);

	// ============================================================
	// Operand fields; clear-accumulator low bits are don't-care
	assign has_file  = (byte_grp && !is_clracc) || bit_grp;
	assign file_addr = is_clracc ? FILE_CLRACC : word[6:0];
	assign dest_file = word[7];
	assign bit_num   = word[9:7];

	// Bit and skip kinds
	assign bit_set_op  = bit_grp && word[11:10] == BIT_SET;
	assign bit_clr_op  = bit_grp && word[11:10] == BIT_CLR;
	assign bit_test    = bit_grp && word[11];
	assign skip_on_set = bit_grp && word[11:10] == BIT_SKIPSET;
	assign skip_dec    = top2 == TOP_BYTE && nib == NIB_DECSKIP;
	assign skip_inc    = top2 == TOP_BYTE && nib == NIB_INCSKIP;

	// ============================================================
	// Pointer selection: explicit pointer ops or file address 0/1
	assign ptr_op   = word[13:4] == OP_PTR;
	assign ind_file = has_file && word[6:1] == IND_ADDR_HI;
	assign ptr_num  = ptr_op ? word[2] : word[0];
	assign ptr_mode = word[1:0];

	// ============================================================
	// Cycle count before any skip decision
	assign two_cycle = word[13:11] == OP_CALL || word[13:11] == OP_JUMP ||
	                   word[13:8] == OP_RETLIT || word[13:9] == OP_RELBR ||
	                   (ctl_grp && (ctl_low == CTL_CALLACC || ctl_low == CTL_RET ||
	                    ctl_low == CTL_RETINT || ctl_low == CTL_BRACC));
	assign ind_extra = (ind_file || ptr_op) && ptr_prog_mem[ptr_num];
	assign base_last = {1'b0, two_cycle} + {1'b0, ind_extra};

endmodule : iwdt_field_decode

//--- iwdt_file_model.sv
`timescale 1ns/1ps
module iwdt_file_model
	import iwdt_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic [6:0] file_addr,
	input  wire logic       file_rd,
	input  wire logic       file_wr,
	input  wire logic [7:0] file_wr_data,
	input  wire logic [7:0] alu_operand,
	output logic [7:0]      file_rd_data,
	output logic [7:0]      alu_result
);
	// ============================================================
	// Register file and stand-in arithmetic unit
	logic [7:0] mem [0:127];
	logic [7:0] last_rd = 8'h00;

	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'h00;
		end
	end

	// Data only while selected; otherwise the inverse of the last read, so stale data never passes
	assign file_rd_data = file_rd ? mem[file_addr] : ~last_rd;
	// Fixed mask keeps the expected results easy to work out
	assign alu_result = alu_operand ^ 8'h5A;

	// Store whatever the block hands back
	always @(posedge core_clk) begin
		if (file_rd) begin
			last_rd <= mem[file_addr];
		end
		if (file_wr) begin
			mem[file_addr] <= file_wr_data;
		end
	end

	task automatic load(input logic [6:0] a, input logic [7:0] v);
		mem[a] = v;
	endtask : load
endmodule : iwdt_file_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
	import iwdt_pkg::*;
	// ============================================================
	// Signals
	logic        core_clk      = 1'b0;
	logic        rst_b         = 1'b0;
	logic [3:0]  avs_address   = 4'h0;
	logic        avs_read      = 1'b0;
	logic        avs_write     = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [1:0]  pm            = 2'h0;
	logic [31:0] avs_readdata, rd;
	logic        avs_waitrequest, file_rd, file_wr, acc_wr, ptr_sel, ptr_step, ptr_down;
	logic        cycle_tick, instr_done, skip_next, last_skip;
	logic [6:0]  file_addr;
	logic [7:0]  file_rd_data, alu_result, file_wr_data, acc_wr_data, alu_operand;
	logic [7:0]  qcnt, n_tick, n_rd, n_fw, n_aw, n_step, step_q, wdat, adat;
	logic [13:0] two_cyc [8] = '{14'h2000, 14'h2800, 14'h0008, 14'h0009,
	                             14'h000A, 14'h000B, 14'h3455, 14'h3200};
	logic [13:0] sk_w [4]    = '{14'h1E32, 14'h1A32, 14'h1C32, 14'h1832};
	int          fails       = 0;
	int          n_tests     = 0;
	int          wt, k, base;

	always #4 core_clk = ~core_clk;

	iwdt_core u_dut (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.file_rd_data(file_rd_data), .alu_result(alu_result), .ptr_prog_mem(pm),
		.file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr),
		.file_wr_data(file_wr_data), .acc_wr(acc_wr), .acc_wr_data(acc_wr_data),
		.alu_operand(alu_operand), .ptr_sel(ptr_sel), .ptr_step(ptr_step),
		.ptr_down(ptr_down), .cycle_tick(cycle_tick), .instr_done(instr_done),
		.skip_next(skip_next));

	iwdt_file_model u_mem (.core_clk(core_clk), .file_addr(file_addr), .file_rd(file_rd),
		.file_wr(file_wr), .file_wr_data(file_wr_data), .alu_operand(alu_operand),
		.file_rd_data(file_rd_data), .alu_result(alu_result));

	// ============================================================
	// Checking and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim

	// Extra edge after release so a write is never held into a repeat
	task automatic av_write(input logic [3:0] a, input logic [31:0] d, output int w);
		w = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) begin
			w++;
			@(posedge core_clk);
		end
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask : av_write

	task automatic av_read(input logic [3:0] a, output logic [31:0] d);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) @(posedge core_clk);
		d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask : av_read

	// Negative expectations mean the count is left open for that opcode
	task automatic run(input logic [13:0] w, input int n, r, f, a, s);
		av_write(OFS_INSTR, {18'h0, w}, wt);
		while (instr_done !== 1'b1) @(posedge core_clk);
		@(posedge core_clk);
		chk(n_tick, n, "instruction cycles");
		if (r >= 0) chk(n_rd, r, "file reads");
		if (f >= 0) chk(n_fw, f, "file stores");
		if (a >= 0) chk(n_aw, a, "accumulator stores");
		chk(last_skip, s, "skip flag");
	endtask : run

	// ============================================================
	// Monitor: strobe counts since the last accepted instruction
	always @(posedge core_clk) begin
		if (avs_write && !avs_waitrequest && avs_address == OFS_INSTR) begin
			{qcnt, n_tick, n_rd, n_fw, n_aw, n_step} <= '0;
			last_skip <= 1'b0;
		end else begin
			qcnt <= cycle_tick ? 8'h00 : qcnt + 8'h01;
			n_tick <= n_tick + 8'(cycle_tick);
			n_rd <= n_rd + 8'(file_rd);
			n_fw <= n_fw + 8'(file_wr);
			n_aw <= n_aw + 8'(acc_wr);
			n_step <= n_step + 8'(ptr_step);
			if (ptr_step) step_q <= qcnt;
			if (instr_done) last_skip <= skip_next;
			if (file_wr) wdat <= file_wr_data;
			if (acc_wr) adat <= acc_wr_data;
			if (cycle_tick === 1'b1) chk(qcnt, 3, "clocks per cycle");
		end
	end

	// Watchdog: about 37 instructions of at most 16 clocks plus bus time, far below this
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		end_sim;
	end

	// ============================================================
	// Tests
	initial begin
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (k = 0; k < 4; k++) begin
			av_read(4'(k * 4), rd);
			// Idle word decodes as control group, so status shows group 2
			chk(rd, (k == 1) ? 32'h00000004 : 32'h00000000, "reset value");
		end
		$display("test reset finished");
		u_mem.load(7'h25, 8'h3C);
		run(14'h07A5, 1, 1, 1, 0, 0);
		chk(wdat, 8'h66, "stored value");
		run(14'h0725, 1, 1, 0, 1, 0);
		chk(adat, 8'h3C, "accumulator value");
		chk(u_mem.mem[7'h25], 8'h66, "file kept");
		run(14'h00A5, 1, 1, 1, 0, 0);
		for (k = 0; k < 4; k++) run(14'h0100 | 14'(k), 1, 0, 0, 1, 0);
		$display("test byte finished");
		u_mem.load(7'h30, 8'hFF);
		run(14'h11B0, 1, 1, 1, 0, 0);
		chk(wdat, 8'hF7, "bit clear");
		run(14'h17B1, 1, 1, 1, 0, 0);
		chk(wdat, 8'h80, "bit set");
		chk(file_addr, 7'h31, "file address");
		av_read(OFS_DECODE, rd);
		chk(rd & 32'h0000477F, 32'h00004731, "decoded fields");
		av_read(OFS_STATUS, rd);
		chk(rd[2:1], GRP_BIT, "bit group");
		u_mem.load(7'h32, 8'h10);
		for (k = 0; k < 4; k++) run(sk_w[k], k % 3 == 0 ? 2 : 1, 1, 0, 0, k % 3 == 0);
		$display("test bit finished");
		u_mem.load(7'h33, 8'h02);
		run(14'h0BB3, 1, 1, 1, 0, 0);
		chk(wdat, 8'h01, "count down");
		run(14'h0BB3, 2, 1, 1, 0, 1);
		u_mem.load(7'h34, 8'hFF);
		run(14'h0FB4, 2, 1, 1, 0, 1);
		chk(wdat, 8'h00, "count up wrap");
		run(14'h0F34, 1, 1, 0, 1, 0);
		chk(adat, 8'h01, "count up to accumulator");
		$display("test count skip finished");
		foreach (two_cyc[i]) run(two_cyc[i], 2, 0, 0, -1, 0);
		run(14'h3012, 1, 0, 0, -1, 0);
		$display("test control finished");
		pm <= 2'h1;
		run(14'h0780, 2, -1, -1, -1, 0);
		pm <= 2'h2;
		run(14'h0780, 1, -1, -1, -1, 0);
		run(14'h0781, 2, -1, -1, -1, 0);
		pm <= 2'h0;
		run(14'h0781, 1, -1, -1, -1, 0);
		for (k = 0; k < 4; k++) begin
			run(14'h0014 | 14'(k), 1, -1, -1, -1, 0);
			chk(ptr_sel, 1, "pointer number");
			chk(ptr_down, k % 2, "pointer direction");
			chk(n_step, 1, "pointer steps");
			chk(step_q, (k / 2) * 3, "pre or post step");
		end
		run(14'h001A, 1, -1, -1, -1, 0);
		chk(ptr_sel, 0, "pointer number");
		chk(step_q, 3, "post step");
		$display("test indirect finished");
		av_read(OFS_RETIRED, rd);
		base = rd;
		av_write(OFS_INSTR, 32'h00002000, wt);
		av_write(OFS_INSTR, 32'h00003012, wt);
		chk(32'(wt >= 5), 1, "write stalled while busy");
		while (instr_done !== 1'b1) @(posedge core_clk);
		@(posedge core_clk);
		av_read(OFS_RETIRED, rd);
		chk(rd, base + 2, "retired count");
		av_read(OFS_INSTR, rd);
		chk(rd, 32'h00003012, "instruction word");
		av_write(4'h2, 32'hFFFFFFFF, wt);
		av_read(4'h2, rd);
		chk(rd, 32'h0, "unmapped read");
		$display("test bus finished");
		end_sim;
	end
endmodule : testbench
